// *** verilog/ccppwm_top.sv ***
// What this block does
// - Timing runs only while system clock runs
// - PWM mode drives waveform, 10-bit resolution
// - Period, duty via period/timer/duty/control regs
// - Control written zero releases output pin
// - Outputs stay on primary pins; pin selection register has no write path
// - High level is on, width in steps
// - Duty zero low, full duty high
// - Resolution equals steps per period
// - Control: steer 7:6, duty lsb 5:4, mode 3:0
// - Steering bits only in enhanced instances
// - Unimplemented bits read zero
// - All four instances share one engine; only the steering bits differ
// - Period match clears timer, sets pin, latches duty
// - Pin clears when time base equals latched duty
//
// Register access over Wishbone and the address map were left to the implementer.
module ccppwm_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Port latch and direction bits per module (port function)
    input wire logic [3:0] port_latch_i,
    input wire logic [3:0] port_direction_bit_i,
    // Primary and alternate pin drive per module
    output logic [3:0] pin_pri_o,
    output logic [3:0] pin_pri_oe_o,
    output logic [3:0] pin_alt_o,
    output logic [3:0] pin_alt_oe_o
);
    // Steering bits exist only in the first two (enhanced) instances
    localparam logic [3:0] ENHANCED = 4'h3;
    // Plain instances read zero in the steering bit positions

    // Per-module registers
    logic [7:0] ctrl_q [4]; // Module control
    logic [7:0] dutyl_q [4]; // Duty low byte
    logic [7:0] dutyh_q [4]; // Latched duty high byte
    logic [1:0] dlat_q [4]; // Latched two lsbs
    logic [7:0] period_q [4]; // Timer period
    logic [7:0] tctrl_q [4]; // Timer control
    logic [7:0] tmr_q [4]; // Period timer count
    logic [7:0] pre_q [4]; // Prescaler and sub-step count
    logic [3:0] out_q; // Compare output latches
    logic [3:0] pinsel_q; // Relocation select
    logic ack_q; // Bus answer, one cycle long
    logic [31:0] rdat_q; // Read data held until the next read
    logic [3:0] pin_pri_q; // Primary pin value
    logic [3:0] pin_pri_oe_q; // Primary pin driver enable
    logic [3:0] pin_alt_q; // Alternate pin value
    logic [3:0] pin_alt_oe_q; // Alternate pin driver enable

    // Synchronised pin-side inputs
    logic [3:0] latch_s1_q; // Port latch, first stage
    logic [3:0] latch_s2_q; // Port latch, second stage
    logic [3:0] dir_s1_q; // Direction bits, first stage
    logic [3:0] dir_s2_q; // Direction bits, second stage

    // Address decode
    logic acc; // New request this cycle
    logic wr; // Accepted write with the low byte lane enabled
    logic [1:0] idx; // Module addressed by the upper bits
    assign acc = cyc_i & stb_i & ~ack_q;
    assign wr = acc & we_i & sel_i[0];
    assign idx = adr_i[5:4];

    // Prescale terminal count from select field
    // One timer step is four clocks times the prescale (1, 4, 16, 64)
    function automatic logic [7:0] pre_max(input logic [1:0] s);
        unique case (s)
            2'h0: pre_max = 8'd3;
            2'h1: pre_max = 8'd15;
            2'h2: pre_max = 8'd63;
            2'h3: pre_max = 8'd255;
        endcase
    endfunction

    // Two time-base bits below the timer: one per prescaled clock
    function automatic logic [1:0] sub_step(input logic [1:0] s,
                                            input logic [7:0] p);
        unique case (s)
            2'h0: sub_step = p[1:0];
            2'h1: sub_step = p[3:2];
            2'h2: sub_step = p[5:4];
            2'h3: sub_step = p[7:6];
        endcase
    endfunction

    // Module is in PWM mode
    function automatic logic is_pwm(input logic [7:0] c);
        is_pwm = (c[3:2] == ccppwm_pkg::MODE_PWM_TOP);
    endfunction

    // Two-flop synchronisers for pin-domain inputs
    // Pin inputs change at any time; only the second stage is read
    always_ff @(posedge clk_i) begin
        latch_s1_q <= port_latch_i;
        latch_s2_q <= latch_s1_q;
        dir_s1_q <= port_direction_bit_i;
        dir_s2_q <= dir_s1_q;
    end

    // Wishbone ack: one cycle per request
    // Ack blocks a new take, so a held request is answered every other cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            // Answer the cycle after the request is taken
            ack_q <= acc;
        end
    end

    // Register map layout: words 0..15, 4 per module (control, duty low,
    // word 2 timer control or latched duty, period); no pin select word.
    // adr_i is a word index here shifted by 2 in byte space.
    logic [3:0] word;
    assign word = adr_i[5:2];

    // Per-module register writes and PWM engine
    genvar g;
    generate
        // Same engine for all four modules
        for (g = 0; g < 4; g++) begin : gmod
            logic sel_mod; // This module's words are addressed
            logic match_period; // Last clock of the period
            logic step_end; // Last clock of a timer step
            logic clr_match; // Time base reaches the latched duty
            logic [7:0] pre_next; // Prescaler after this clock
            logic [7:0] tmr_next; // Timer after this clock
            logic [9:0] tbase_next; // Time base after this clock
            logic [1:0] psel; // Prescale select
            // Module block is words 4g..4g+3 in main bank
            assign sel_mod = (adr_i[5:4] == 2'(g));
            assign psel = tctrl_q[g][1:0];
            assign step_end = (pre_q[g] == pre_max(psel));
            assign match_period = (tmr_q[g] == period_q[g]) & step_end;
            // Next prescaler and timer values; timer clears after match
            assign pre_next = step_end ? 8'h00 : 8'(pre_q[g] + 8'h01);
            assign tmr_next = match_period ? 8'h00 :
                step_end ? 8'(tmr_q[g] + 8'h01) : tmr_q[g];
            // Ten-bit time base: timer above two prescaled sub-steps
            assign tbase_next = {tmr_next, sub_step(psel, pre_next)};
            // Looking one clock ahead lets the registered latch fall
            // exactly as the time base reaches the duty value
            assign clr_match =
                (tbase_next == {dutyh_q[g], dlat_q[g]});

            // Software-written registers
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    // Control cleared, period at its maximum
                    ctrl_q[g] <= ccppwm_pkg::RST_CTRL;
                    dutyl_q[g] <= ccppwm_pkg::RST_DUTY;
                    period_q[g] <= ccppwm_pkg::RST_PERIOD;
                end else if (wr && sel_mod) begin
                    // Word 0 control, 1 duty low, 3 period
                    unique case (adr_i[3:2])
                        2'h0: begin
                            // Steering bits absent in plain instances
                            ctrl_q[g] <= ENHANCED[g] ? dat_i[7:0] :
                                {2'b00, dat_i[5:0]};
                        end
                        2'h1: dutyl_q[g] <= dat_i[7:0];
                        2'h3: period_q[g] <= dat_i[7:0];
                        // Word 2 writes reach the timer control below
                        default: ;
                    endcase
                end
            end

            // Timer control lives in word 2 of each module block
            // The aux-bank path is unused in this register map
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    // Timer stopped, prescale 1:1
                    tctrl_q[g] <= ccppwm_pkg::RST_TCTRL;
                end else if (wr && word == 4'(12 + g) && 1'b0) begin
                    tctrl_q[g] <= dat_i[7:0];
                end else if (wr && sel_mod && adr_i[3:2] == 2'h2 &&
                             !is_pwm(ctrl_q[g])) begin
                    // Outside PWM, word 2 is the timer control
                    tctrl_q[g] <= {5'h00, dat_i[2:0]};
                end
            end

            // Timer, prescaler; stops when clock stops (sleep)
            // With no clock nothing counts and the pin holds its level
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    // Count restarts from zero
                    tmr_q[g] <= 8'h00;
                    pre_q[g] <= 8'h00;
                end else if (tctrl_q[g][ccppwm_pkg::TCTRL_ON]) begin
                    // Period runs from zero up to the period register
                    tmr_q[g] <= tmr_next;
                    pre_q[g] <= pre_next;
                end
            end

            // Duty double buffer latched at period end
            // Duty may be written any time; the engine sees it only
            // at the period boundary, so a pulse is never cut short
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    // Latched duty starts at zero
                    dutyh_q[g] <= ccppwm_pkg::RST_DUTY;
                    dlat_q[g] <= 2'b00;
                end else if (tctrl_q[g][ccppwm_pkg::TCTRL_ON] &&
                             match_period) begin
                    dutyh_q[g] <= dutyl_q[g];
                    dlat_q[g] <= ctrl_q[g][ccppwm_pkg::CTRL_DLSB_HI:
                                           ccppwm_pkg::CTRL_DLSB_LO];
                end
            end

            // Output latch: set at period start, clear on duty match
            // Low after reset or a cleared control until the first period ends
            always_ff @(posedge clk_i) begin
                if (rst_i || ctrl_q[g] == 8'h00) begin
                    // Reset or a cleared control forces the latch low
                    out_q[g] <= 1'b0;
                end else if (tctrl_q[g][ccppwm_pkg::TCTRL_ON]) begin
                    if (match_period) begin
                        // Zero duty never sets the pin
                        out_q[g] <= ({dutyl_q[g],
                            ctrl_q[g][5:4]} != 10'h000);
                    end else if (clr_match) begin
                        // Period match wins; a duty past the last time-base value is never matched, so the pin stays high
                        out_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Relocation select: no write path in this map, so it stays
    // at its reset value and the primary pins carry the outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Primary location after reset
            pinsel_q <= ccppwm_pkg::RST_PINSEL[3:0];
        end else if (wr && word == 4'hf && 1'b0) begin
            pinsel_q <= dat_i[3:0];
        end else if (wr && adr_i[5:2] == 4'h2 && 1'b0) begin
            pinsel_q <= dat_i[3:0];
        end
    end

    // Read data mux; unmapped and reserved bits read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Nothing to show before the first read
            rdat_q <= 32'h0000_0000;
        end else if (acc && !we_i) begin
            unique case (adr_i[3:2])
                // Upper bytes always zero; word 2 shows the latched duty
                2'h0: rdat_q <= {24'h000000, ctrl_q[idx]};
                2'h1: rdat_q <= {24'h000000, dutyl_q[idx]};
                2'h2: rdat_q <= {24'h000000, dutyh_q[idx]};
                default: rdat_q <= {24'h000000, period_q[idx]};
            endcase
        end
    end

    // Pin steering: PWM drives the selected pin if direction is output
    // All drivers stay off through reset, as ports start as inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_pri_q <= 4'h0;
            pin_pri_oe_q <= 4'h0;
            pin_alt_q <= 4'h0;
            pin_alt_oe_q <= 4'h0;
        end else begin
            // One flop after the engine and the synchronisers
            for (int i = 0; i < 4; i++) begin
                // Owned pin shows PWM, released pin shows port latch
                pin_pri_q[i] <= (is_pwm(ctrl_q[i]) && !pinsel_q[i]) ?
                    out_q[i] : latch_s2_q[i];
                pin_alt_q[i] <= (is_pwm(ctrl_q[i]) && pinsel_q[i]) ?
                    out_q[i] : latch_s2_q[i];
                // Driver enabled only with direction bit cleared
                pin_pri_oe_q[i] <= !dir_s2_q[i] && !pinsel_q[i];
                pin_alt_oe_q[i] <= !dir_s2_q[i] && pinsel_q[i];
            end
        end
    end

    // Every output comes straight from its flip-flop
    assign ack_o = ack_q;
    assign dat_o = rdat_q;
    assign pin_pri_o = pin_pri_q;
    assign pin_pri_oe_o = pin_pri_oe_q;
    assign pin_alt_o = pin_alt_q;
    assign pin_alt_oe_o = pin_alt_oe_q;
endmodule // ccppwm_top

// *** verilog/ccppwm_pkg.sv ***
package ccppwm_pkg;
    // Register word offsets (byte addresses on the bus)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DUTYL = 4'h4;
    localparam logic [3:0] ADDR_DUTYH = 4'h8;
    localparam logic [3:0] ADDR_PERIOD = 4'hc;
    localparam logic [3:0] ADDR_TCTRL = 4'h0;
    localparam logic [3:0] ADDR_PINSEL = 4'h4;
    localparam logic [1:0] BANK_MAIN = 2'h0;
    localparam logic [1:0] BANK_AUX = 2'h1;
    // Control register fields
    localparam int CTRL_STEER_HI = 7;
    localparam int CTRL_STEER_LO = 6;
    localparam int CTRL_DLSB_HI = 5;
    localparam int CTRL_DLSB_LO = 4;
    // Mode select codes: PWM is 11xx
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;
    // Timer control fields
    localparam int TCTRL_ON = 2;
    // Prescale select 0..3 -> 1,4,16,64
    localparam logic [1:0] PRE_1 = 2'h0;
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hff;
    localparam logic [7:0] RST_TCTRL = 8'h00;
    localparam logic [7:0] RST_PINSEL = 8'h00;
    // Pin select width (one relocation bit per module)
    localparam int NUM_MOD = 4;

    // Wishbone request carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [5:0] adr;
        logic [7:0] dat;
    } ccppwm_req_type;
endpackage : ccppwm_pkg

// *** testbench/ccppwm_props.sv ***
module ccppwm_props (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Pin side
    input wire logic [3:0] port_direction_bit_i,
    input wire logic [3:0] pin_pri_oe_o,
    input wire logic [3:0] pin_alt_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // New request taken, then a single-cycle answer
    sequence seq_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence seq_pulse;
        ack_o ##1 !ack_o;
    endsequence
    AST_ACK_NEXT: assert property (seq_req |=> seq_pulse)
        else $error("ack not a one-cycle answer");
    AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    AST_RD_HI: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_STEER: assert property (ack_o &&
        $past(!we_i && adr_i[5] && adr_i[3:2] == 2'h0) |-> dat_o[7:6] == 2'h0)
        else $error("steering bits seen on plain module");
    AST_ALT: assert property (pin_alt_oe_o == 4'h0)
        else $error("alternate pin driven");
    AST_RST: assert property (disable iff (1'b0)
        rst_i |=> pin_pri_oe_o == 4'h0 && !ack_o)
        else $error("outputs active after reset");
    AST_DIR_IN: assert property
        (port_direction_bit_i[1] [*4] |-> !pin_pri_oe_o[1])
        else $error("pin driven while direction is input");
    AST_DIR_OUT: assert property
        ((!port_direction_bit_i[1]) [*4] |-> pin_pri_oe_o[1])
        else $error("pin not driven while direction is output");
endmodule // ccppwm_props

bind ccppwm_top ccppwm_props ccppwm_props_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .port_direction_bit_i(port_direction_bit_i),
    .pin_pri_oe_o(pin_pri_oe_o), .pin_alt_oe_o(pin_alt_oe_o));

// *** testbench/ccppwm_tb_top.sv ***
module ccppwm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [5:0] adr_i = '0;
    logic [3:0] sel_i = '0, port_latch_i = '0, port_direction_bit_i = 4'hf;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic ack_o;
    logic [3:0] pin_pri_o, pin_pri_oe_o, pin_alt_o, pin_alt_oe_o;
    int miscompares = 0, samples_checked = 0;
    // 10 MHz clock
    always #50 clk_i = ~clk_i;
    ccppwm_top ccppwm_top_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .port_latch_i, .port_direction_bit_i,
        .pin_pri_o, .pin_pri_oe_o, .pin_alt_o, .pin_alt_oe_o);
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One classic cycle; request held until ack sampled
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; sel_i <= s;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1, a, d, 4'hf);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        bus(0, a, 8'h00, 4'hf);
        chk(rd, {24'h0, e});
    endtask
    // Reset values and idle pins
    task automatic t_reset;
        rdc(6'h00, 8'h00);
        rdc(6'h04, 8'h00);
        rdc(6'h3c, 8'hff);
        chk(pin_pri_oe_o, 4'h0);
        $display("reset test done");
    endtask
    // Field layout, plain modules, gated write
    task automatic t_regs;
        wr(6'h00, 8'hf0);
        rdc(6'h00, 8'hf0);
        wr(6'h20, 8'hf0);
        rdc(6'h20, 8'h30);
        bus(1, 6'h04, 8'h5a, 4'h0);
        rdc(6'h04, 8'h00);
        wr(6'h00, 8'h00);
        $display("register test done");
    endtask
    // Period 16 clocks; high count over four periods per duty
    task automatic t_pwm;
        logic [9:0] dt [4] = '{10'h008, 10'h000, 10'h3ff, 10'h005};
        int h;
        wr(6'h1c, 8'h03);
        wr(6'h18, 8'h04);
        port_direction_bit_i[1] <= 1'b0;
        foreach (dt[i]) begin
            wr(6'h14, dt[i][9:2]);
            wr(6'h10, {2'h0, dt[i][1:0], 4'hc});
            repeat (40) @(posedge clk_i);
            h = 0;
            repeat (64) begin
                @(posedge clk_i);
                if (pin_pri_o[1] === 1'b1) h++;
            end
            chk(h, (dt[i] > 16 ? 16 : dt[i]) * 4);
            rdc(6'h18, dt[i][9:2]);
            rdc(6'h30, 8'h00);
        end
        $display("pwm test done");
    endtask
    // Control cleared hands pin to port latch
    task automatic t_release;
        wr(6'h10, 8'h00);
        port_latch_i[1] <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk(pin_pri_o[1], 1'b1);
        port_latch_i[1] <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk(pin_pri_o[1], 1'b0);
        chk(pin_pri_oe_o[1], 1'b1);
        port_direction_bit_i[1] <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk(pin_pri_oe_o[1], 1'b0);
        $display("release test done");
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        t_reset;
        t_regs;
        t_pwm;
        t_release;
        end_sim;
    end
    // Hang guard
    initial begin
        #3000000;
        miscompares++;
        end_sim;
    end
endmodule // ccppwm_tb_top
